// ===== css_clock_startup.v
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "css_clock_defs.vh"
`default_nettype none

module css_clock_startup #(
	parameter SYNC_N = 4
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Fuse inputs
	input wire [2:0] fuse_source_select_high,
	input wire fuse_source_select_low,
	input wire [1:0] fuse_startup_time,
	input wire fuse_clock_output_enable,
	// Asynchronous pins: source osc, watchdog osc, PLL lock, divided clock
	input wire src_osc_clk,
	input wire wdt_osc_clk,
	input wire pll_lock_raw,
	input wire prescaled_clk,
	// Same-domain controls
	input wire sleep_power_down,
	input wire prescaler_active,
	// Clock control outputs
	output reg sys_clk_release,
	output reg rc_osc_run,
	output reg pll_run,
	output reg [1:0] pll_ref_select,
	output reg [3:0] pll_mult_factor,
	output reg [1:0] osc_amp_mode,
	output reg osc_amp_enable,
	output reg system_clock_output_pin,
	output reg system_clock_output_pin_oe,
	output reg irq
);

	localparam [4:0] S_LATCH = 5'h01;
	localparam [4:0] S_OSC = 5'h02;
	localparam [4:0] S_RST14 = 5'h04;
	localparam [4:0] S_WDT = 5'h08;
	localparam [4:0] S_RUN = 5'h10;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg from_reset_q;
	reg [6:0] clksel_q;
	reg pll_en_q;
	reg [3:0] pmul_q;
	reg [2:0] stat_q;
	reg [2:0] mask_q;
	reg [14:0] osc_cnt_q;
	reg [13:0] wdt_cnt_q;
	reg [SYNC_N-1:0] meta_q;
	reg [SYNC_N-1:0] sync_q;
	reg src_last_q;
	reg wdt_last_q;
	reg lock_last_q;
	reg [14:0] su_count;
	reg [13:0] wd_count;
	reg [2:0] ev_set;
	reg [31:0] rd_word;
	reg rd_ok;

	wire [3:0] sel = clksel_q[3:0];
	wire [1:0] sut = clksel_q[`CSS_SUT_LSB+1:`CSS_SUT_LSB];
	wire [3:0] fuse_sel = {fuse_source_select_high, fuse_source_select_low};
	wire src_sync = sync_q[0];
	wire wdt_sync = sync_q[1];
	wire lock_sync = sync_q[2];
	wire div_sync = sync_q[3];
	wire src_tick = src_sync & ~src_last_q;
	wire wdt_tick = wdt_sync & ~wdt_last_q;
	wire pll_locked_flag = pll_en_q & lock_sync;
	wire apb_acc = psel & penable & pready;
	wire apb_wr = apb_acc & pwrite;
	wire sel_is_pll = (fuse_sel == `CSS_SEL_PLL_RC) | (fuse_sel == `CSS_SEL_PLL_XTAL) |
		(fuse_sel == `CSS_SEL_PLL_EXT);

	// Two-stage synchronisers for every pin input; first stage read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_sync
			wire pin_in;
			assign pin_in = (gi == 0) ? src_osc_clk : (gi == 1) ? wdt_osc_clk :
				(gi == 2) ? pll_lock_raw : prescaled_clk;
			always @(posedge sys_clk) begin
				if (rst) begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end else begin
					meta_q[gi] <= pin_in;
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	// Start-up counts from select code and start-up code
	always @* begin
		su_count = `CSS_SU_6;
		wd_count = `CSS_WD_NONE;
		if (sel[3]) begin
			case ({sel[0], sut})
				3'h0: begin
					su_count = `CSS_SU_258;
					wd_count = `CSS_WD_4MS;
				end
				3'h1: begin
					su_count = `CSS_SU_258;
					wd_count = `CSS_WD_64MS;
				end
				3'h2: su_count = `CSS_SU_1K;
				3'h3: begin
					su_count = `CSS_SU_1K;
					wd_count = `CSS_WD_4MS;
				end
				3'h4: begin
					su_count = `CSS_SU_1K;
					wd_count = `CSS_WD_64MS;
				end
				3'h5: su_count = `CSS_SU_16K;
				3'h6: begin
					su_count = `CSS_SU_16K;
					wd_count = `CSS_WD_4MS;
				end
				default: begin
					su_count = `CSS_SU_16K;
					wd_count = `CSS_WD_64MS;
				end
			endcase
		end else if (sel == `CSS_SEL_PLL_EXT) begin
			su_count = `CSS_SU_16K;
			case (sut)
				2'h0: wd_count = `CSS_WD_NONE;
				2'h3: wd_count = `CSS_WD_64MS;
				default: wd_count = `CSS_WD_4MS;
			endcase
		end else begin
			// Crystal or RC fed PLL takes 1K (crystal 16K on start-up code 3), plain sources 6 cycles
			if ((sel == `CSS_SEL_PLL_XTAL) | (sel == `CSS_SEL_PLL_RC)) begin
				su_count = `CSS_SU_1K;
			end
			case (sut)
				2'h0: wd_count = `CSS_WD_NONE;
				2'h1: wd_count = `CSS_WD_4MS;
				2'h2: wd_count = `CSS_WD_64MS;
				default: begin
					// Reserved code falls back to the longest delay, which is the safe side; PLL from crystal takes 16K with no watchdog delay
					wd_count = `CSS_WD_64MS;
					if (sel == `CSS_SEL_PLL_XTAL) begin
						su_count = `CSS_SU_16K;
						wd_count = `CSS_WD_NONE;
					end
				end
			endcase
		end
	end

	// Start-up sequencer next state
	always @* begin
		state_d = state_q;
		case (state_q)
			S_LATCH: state_d = S_OSC;
			S_OSC: begin
				if (src_tick & (osc_cnt_q + 15'h0001 >= su_count)) begin
					state_d = from_reset_q ? S_RST14 : S_RUN;
				end
			end
			S_RST14: begin
				if (src_tick & (osc_cnt_q + 15'h0001 >= `CSS_RST_CK)) begin
					state_d = (wd_count == `CSS_WD_NONE) ? S_RUN : S_WDT;
				end
			end
			S_WDT: begin
				if (wdt_tick & (wdt_cnt_q + 14'h0001 >= wd_count)) begin
					state_d = S_RUN;
				end
			end
			S_RUN: begin
				// Waking from power-down recounts the source without the reset delay
				if (sleep_power_down) begin
					state_d = S_OSC;
				end
			end
			default: state_d = S_LATCH;
		endcase
	end

	// Sequencer and counters
	always @(posedge sys_clk) begin
		if (rst) begin
			state_q <= S_LATCH;
			from_reset_q <= 1'b1;
			osc_cnt_q <= 15'h0000;
			wdt_cnt_q <= 14'h0000;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) begin
				osc_cnt_q <= 15'h0000;
				wdt_cnt_q <= 14'h0000;
			end else begin
				if (src_tick) begin
					osc_cnt_q <= osc_cnt_q + 15'h0001;
				end
				if (wdt_tick) begin
					wdt_cnt_q <= wdt_cnt_q + 14'h0001;
				end
			end
			if (state_q == S_RUN) begin
				from_reset_q <= 1'b0;
			end
			// Hold the counter in sleep so the wake count starts from zero
			if (sleep_power_down) begin
				osc_cnt_q <= 15'h0000;
			end
		end
	end

	// Edge history for the synchronised pins
	always @(posedge sys_clk) begin
		if (rst) begin
			src_last_q <= 1'b0;
			wdt_last_q <= 1'b0;
			lock_last_q <= 1'b0;
		end else begin
			src_last_q <= src_sync;
			wdt_last_q <= wdt_sync;
			lock_last_q <= pll_locked_flag;
		end
	end

	// Select register: fuses caught right after reset, then software owned
	always @(posedge sys_clk) begin
		if (rst) begin
			clksel_q <= 7'h00;
			pll_en_q <= 1'b0;
			pmul_q <= `CSS_PMUL_RESET;
		end else if (state_q == S_LATCH) begin
			clksel_q <= {fuse_clock_output_enable, fuse_startup_time, fuse_sel};
			pll_en_q <= sel_is_pll;
			pmul_q <= `CSS_PMUL_RESET;
		end else if (apb_wr & (paddr == `CSS_OFF_CLKSEL)) begin
			clksel_q <= pwdata[6:0];
		end else if (apb_wr & (paddr == `CSS_OFF_PLLCS)) begin
			pll_en_q <= pwdata[`CSS_PLL_RUN_ENABLE_BIT];
			pmul_q <= pwdata[`CSS_PMUL_LSB+3:`CSS_PMUL_LSB];
		end
	end

	// Sticky events; a new event beats a write-one clear in the same cycle
	always @* begin
		ev_set = 3'h0;
		ev_set[`CSS_EV_STARTED] = (state_d == S_RUN) & (state_q != S_RUN);
		ev_set[`CSS_EV_LOCK] = pll_locked_flag & ~lock_last_q;
		ev_set[`CSS_EV_UNLOCK] = ~pll_locked_flag & lock_last_q;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			stat_q <= 3'h0;
			mask_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			if (apb_wr & (paddr == `CSS_OFF_IRQ_STAT)) begin
				stat_q <= (stat_q & ~pwdata[2:0]) | ev_set;
			end else begin
				stat_q <= stat_q | ev_set;
			end
			if (apb_wr & (paddr == `CSS_OFF_IRQ_MASK)) begin
				mask_q <= pwdata[2:0];
			end
			irq <= |((stat_q | ev_set) & mask_q);
		end
	end

	// Read mux
	always @* begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (paddr)
			`CSS_OFF_CLKSEL: rd_word[6:0] = clksel_q;
			`CSS_OFF_PLLCS: begin
				rd_word[`CSS_PLL_LOCKED_FLAG_BIT] = pll_locked_flag;
				rd_word[`CSS_PLL_RUN_ENABLE_BIT] = pll_en_q;
				rd_word[`CSS_PMUL_LSB+3:`CSS_PMUL_LSB] = pmul_q;
			end
			`CSS_OFF_IRQ_STAT: rd_word[2:0] = stat_q;
			`CSS_OFF_IRQ_MASK: rd_word[2:0] = mask_q;
			`CSS_OFF_STATE: rd_word[4:0] = state_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// APB answer one cycle into the access phase
	always @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rd_ok;
			prdata <= (psel & penable & ~pready & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	// Clock and oscillator controls
	always @(posedge sys_clk) begin
		if (rst) begin
			sys_clk_release <= 1'b0;
			rc_osc_run <= 1'b0;
			pll_run <= 1'b0;
			pll_ref_select <= `CSS_PREF_RC;
			pll_mult_factor <= `CSS_PMUL_RESET;
			osc_amp_mode <= 2'h0;
			osc_amp_enable <= 1'b0;
			system_clock_output_pin <= 1'b0;
			system_clock_output_pin_oe <= 1'b0;
		end else begin
			sys_clk_release <= (state_d == S_RUN) & ~sleep_power_down;
			// RC is unused by the 128k, PLL-from-crystal/ext and crystal codes 4'hC and 4'hD
			rc_osc_run <= ~sleep_power_down & (sel != `CSS_SEL_WD128K) &
				(sel != `CSS_SEL_PLL_XTAL) & (sel != `CSS_SEL_PLL_EXT) & (sel[3:1] != 3'h6);
			pll_run <= pll_en_q & ~sleep_power_down;
			if (sel == `CSS_SEL_PLL_XTAL) begin
				pll_ref_select <= `CSS_PREF_XTAL;
			end else if (sel == `CSS_SEL_PLL_EXT) begin
				pll_ref_select <= `CSS_PREF_EXT;
			end else begin
				pll_ref_select <= `CSS_PREF_RC;
			end
			pll_mult_factor <= pmul_q;
			// Mode 100 is meant for resonators; quartz users must pick a higher mode
			osc_amp_mode <= sel[2:1];
			osc_amp_enable <= (sel[3] | (sel == `CSS_SEL_PLL_XTAL)) & ~sleep_power_down;
			// Pin copy lags the clock by the synchroniser, which is fine for monitoring
			system_clock_output_pin <= prescaler_active ? div_sync : src_sync;
			system_clock_output_pin_oe <= clksel_q[`CSS_REG_CLOCK_OUTPUT_ENABLE_BIT] & (state_q != S_LATCH);
		end
	end

endmodule // css_clock_startup

`default_nettype wire

// ===== css_clock_defs.vh
`ifndef CSS_CLOCK_DEFS_VH
`define CSS_CLOCK_DEFS_VH

// Register byte offsets
`define CSS_OFF_CLKSEL 8'h00
`define CSS_OFF_PLLCS 8'h04
`define CSS_OFF_IRQ_STAT 8'h08
`define CSS_OFF_IRQ_MASK 8'h0C
`define CSS_OFF_STATE 8'h10

// Clock source select register fields
`define CSS_SEL_LOW_BIT 0
`define CSS_SEL_HIGH_LSB 1
`define CSS_SUT_LSB 4
`define CSS_REG_CLOCK_OUTPUT_ENABLE_BIT 6

// PLL control and status register fields
`define CSS_PLL_LOCKED_FLAG_BIT 0
`define CSS_PLL_RUN_ENABLE_BIT 1
`define CSS_PMUL_LSB 4
`define CSS_PMUL_RESET 4'h6

// Interrupt status bits
`define CSS_EV_STARTED 0
`define CSS_EV_LOCK 1
`define CSS_EV_UNLOCK 2

// Source select codes
`define CSS_SEL_EXT_CLK 4'h0
`define CSS_SEL_PLL_RC 4'h1
`define CSS_SEL_RC 4'h2
`define CSS_SEL_WD128K 4'h3
`define CSS_SEL_PLL_XTAL 4'h4
`define CSS_SEL_PLL_EXT 4'h5

// PLL reference codes
`define CSS_PREF_RC 2'h0
`define CSS_PREF_XTAL 2'h1
`define CSS_PREF_EXT 2'h2

// Start-up counts in source oscillator cycles
`define CSS_SU_6 15'h0006
`define CSS_SU_258 15'h0102
`define CSS_SU_1K 15'h0400
`define CSS_SU_16K 15'h4000
`define CSS_RST_CK 15'h000E

// Real-time reset delay in watchdog oscillator cycles
`define CSS_WD_NONE 14'h0000
`define CSS_WD_4MS 14'h0200
`define CSS_WD_64MS 14'h2000

`endif

// ===== css_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
module css_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Inputs watched
	input wire logic sleep_power_down,
	input wire logic prescaler_active,
	input wire logic prescaled_clk,
	input wire logic src_osc_clk,
	// Outputs watched
	input wire logic sys_clk_release,
	input wire logic rc_osc_run,
	input wire logic pll_run,
	input wire logic [1:0] pll_ref_select,
	input wire logic [3:0] pll_mult_factor,
	input wire logic system_clock_output_pin,
	input wire logic system_clock_output_pin_oe
);
	// Cycles since reset release; saturates so long runs never wrap
	logic [7:0] cyc_q;
	logic [7:0] cyc_d;
	assign cyc_d = (cyc_q == 8'hFF) ? cyc_q : cyc_q + 8'h01;
	always @(posedge sys_clk) begin
		cyc_q <= rst ? 8'h00 : cyc_d;
	end
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	property p_rst_quiet;
		disable iff (1'b0) rst |=> !sys_clk_release && !system_clock_output_pin_oe
			&& pll_mult_factor == 4'h6;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("reset state wrong");
	property p_sleep_off;
		sleep_power_down |=> !rc_osc_run && !pll_run;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("oscillator on in sleep");
	property p_sleep_gate;
		sleep_power_down |=> !sys_clk_release;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("clock not gated");
	property p_rel_hold;
		sys_clk_release && !sleep_power_down |=> sys_clk_release;
	endproperty
	a_rel_hold: assert property (p_rel_hold) else $error("clock release dropped");
	// Twenty source edges at two cycles high and low need more than sixty cycles
	property p_rel_min;
		$rose(sys_clk_release) |-> cyc_q > 8'h3C;
	endproperty
	a_rel_min: assert property (p_rel_min) else $error("released too early");
	property p_pin_pre;
		(system_clock_output_pin_oe && prescaler_active && $stable(prescaled_clk)) [*6]
			|-> system_clock_output_pin == prescaled_clk;
	endproperty
	a_pin_pre: assert property (p_pin_pre) else $error("pin not divided clock");
	property p_pin_src;
		(system_clock_output_pin_oe && !prescaler_active && $stable(src_osc_clk)) [*6]
			|-> system_clock_output_pin == src_osc_clk;
	endproperty
	a_pin_src: assert property (p_pin_src) else $error("pin not source clock");
	// A crystal or external reference means the RC oscillator is idle
	property p_ref_ok;
		pll_ref_select != 2'h0 |-> !rc_osc_run && pll_ref_select != 2'h3;
	endproperty
	a_ref_ok: assert property (p_ref_ok) else $error("bad reference select");
endmodule // css_chk
`default_nettype wire

// ===== css_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module css_osc_model #(
	parameter int LOCK_N = 20
) (
	// Clock and test control
	input wire logic sys_clk,
	input wire logic hold,
	input wire logic pll_run,
	// Oscillator side
	output logic src_osc_clk,
	output logic wdt_osc_clk,
	output logic pll_lock_raw
);
	logic [1:0] div_q = 2'h0;
	int lock_q = 0;
	initial begin
		src_osc_clk = 1'b0;
		wdt_osc_clk = 1'b0;
		pll_lock_raw = 1'b0;
	end
	// Quarter rate, two cycles high and low, so the synchroniser never misses an edge
	always @(posedge sys_clk) begin
		div_q <= div_q + 2'h1;
		wdt_osc_clk <= div_q[1];
		if (!hold) begin
			src_osc_clk <= div_q[1]; // Steady nominal reference
		end
	end
	// Lock settles after a while and is lost at once when the loop stops
	always @(posedge sys_clk) begin
		if (!pll_run) begin
			lock_q <= 0;
		end else if (lock_q < LOCK_N) begin
			lock_q <= lock_q + 1;
		end
		pll_lock_raw <= pll_run && lock_q == LOCK_N; // Lock on a reference near nominal
	end
endmodule // css_osc_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`include "css_clock_defs.vh"
`default_nettype none
module tb;
	// Bench drives
	logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, r = 32'h0;
	logic [3:0] f_sel = 4'h0;
	logic [1:0] f_sut = 2'h0;
	logic f_co = 1'b0, hold = 1'b0, pre_clk = 1'b0, pre_act = 1'b0, sleep = 1'b0;
	// Design and partner outputs
	wire [31:0] prdata;
	wire [3:0] mult;
	wire [1:0] pll_ref, amp_mode;
	wire pready, pslverr, src, wdt, lock, rel, rc_run, pll_run, pin, pin_oe, irq, amp_en;
	int error_cnt = 0, n_compared = 0;
	integer seed = 32'h7970B3CC;
	logic [32:0] exp_q[$];
	always #50 sys_clk = ~sys_clk;
	css_clock_startup dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fuse_source_select_high(f_sel[3:1]),
		.fuse_source_select_low(f_sel[0]), .fuse_startup_time(f_sut),
		.fuse_clock_output_enable(f_co), .src_osc_clk(src), .wdt_osc_clk(wdt),
		.pll_lock_raw(lock), .prescaled_clk(pre_clk), .sleep_power_down(sleep),
		.prescaler_active(pre_act), .sys_clk_release(rel), .rc_osc_run(rc_run),
		.pll_run(pll_run), .pll_ref_select(pll_ref), .pll_mult_factor(mult),
		.osc_amp_mode(amp_mode), .osc_amp_enable(amp_en), .system_clock_output_pin(pin),
		.system_clock_output_pin_oe(pin_oe), .irq(irq));
	css_osc_model osc (.sys_clk(sys_clk), .hold(hold), .pll_run(pll_run), .src_osc_clk(src),
		.wdt_osc_clk(wdt), .pll_lock_raw(lock));
	task chk(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Bus answers are compared with the note taken when each request went out
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			chk({pslverr, prdata}, exp_q.pop_front());
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back(e);
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) chk(33'h0, 33'h1);
	endtask
	// Wait for release; with n source edges expected, it comes after about 4n cycles
	task await_rel(input int n);
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (rel !== 1'b1 && k < 4 * n + 40);
		chk(k >= 4 * n - 8 && k <= 4 * n + 16, 1'b1);
	endtask
	// Reset with given fuses, then time the release when n edges are expected
	task boot(input logic [3:0] s, input logic [1:0] t, input logic c, input int n);
		@(posedge sys_clk);
		rst <= 1'b1;
		f_sel <= s;
		f_sut <= t;
		f_co <= c;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		if (n > 0) await_rel(n);
	endtask
	task irqc(input logic e);
		repeat (8) @(posedge sys_clk);
		chk(irq, e);
	endtask
	task stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		boot(4'h0, 2'h0, 1'b1, 20); // External clock start-up
		apb(1'b0, `CSS_OFF_CLKSEL, 32'h0, 33'h40); // Fuses latched
		apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0}); // Unmapped word refused
		pre_clk <= 1'b1;
		pre_act <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk(pin, 1'b1); // Divided clock out
		pre_act <= 1'b0;
		hold <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk({pin_oe, pin}, {1'b1, src}); // Source clock out
		hold <= 1'b0;
		$display("clock out test done");
		// Mode 100 is run as a ceramic resonator here
		for (int m = 0; m < 4; m++) begin
			boot({1'b1, m[1:0], 1'b0}, 2'h2, 1'b0, 0);
			repeat (3) @(posedge sys_clk);
			chk(amp_mode, m[1:0]); // Amplifier mode
		end
		boot(4'hC, 2'h0, 1'b0, 784); // Crystal counts
		chk(pin_oe, 1'b0); // No output when off
		chk(amp_en, 1'b1); // Amplifier runs in crystal mode
		$display("crystal test done");
		boot(4'h4, 2'h0, 1'b0, 1038); // PLL from crystal
		chk({pll_run, pll_ref, mult}, {1'b1, 2'h1, 4'h6}); // Fuse PLL setup
		apb(1'b0, 8'h04, 32'h0, 33'h63); // Lock flag
		apb(1'b0, `CSS_OFF_IRQ_STAT, 32'h0, 33'h3); // Start-up and lock events
		apb(1'b1, `CSS_OFF_IRQ_MASK, 32'h2, 33'h0);
		irqc(1'b1); // Lock event unmasked
		apb(1'b1, `CSS_OFF_IRQ_STAT, 32'h2, 33'h0);
		irqc(1'b0); // Lock event cleared
		apb(1'b1, `CSS_OFF_IRQ_MASK, 32'h7, 33'h0);
		irqc(1'b1); // Start-up event unmasked
		apb(1'b1, `CSS_OFF_IRQ_STAT, 32'h1, 33'h0);
		irqc(1'b0); // Start-up event cleared
		r = $random(seed);
		apb(1'b1, 8'h04, {24'h0, r[3:0], 4'h2}, 33'h0); // Random factor, enabled
		apb(1'b0, 8'h04, 32'h0, {25'h0, r[3:0], 4'h3}); // Factor kept, still locked
		apb(1'b1, 8'h04, {24'h0, r[3:0], 4'h0}, 33'h0); // Disable the loop
		irqc(1'b1); // Unlock event raises the line
		chk(pll_run, 1'b0); // Stops when disabled
		apb(1'b0, `CSS_OFF_IRQ_STAT, 32'h0, 33'h4); // Only the unlock event
		apb(1'b0, 8'h04, 32'h0, {25'h0, r[3:0], 4'h0}); // Lock lost
		$display("pll crystal test done");
		boot(4'h1, 2'h1, 1'b0, 1550); // PLL from RC
		chk({rc_run, pll_run, pll_ref}, {2'h3, 2'h0}); // RC reference
		sleep <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({rc_run, pll_run, rel}, 3'h0); // Off in sleep
		sleep <= 1'b0;
		await_rel(1024); // Wake counts 1K edges, no reset delay
		chk({rc_run, amp_en}, 2'h2); // RC back on, amplifier idle
		$display("pll rc test done");
		boot(4'h5, 2'h0, 1'b0, 16398); // PLL from external clock
		chk(pll_ref, 2'h2); // External reference
		$display("pll external test done");
		stop_test();
	end
	// Longest path is about 84000 cycles
	initial begin
		repeat (95000) @(posedge sys_clk);
		error_cnt++;
		stop_test();
	end
endmodule // tb
bind css_clock_startup css_chk u_chk (.sys_clk(sys_clk), .rst(rst),
	.sleep_power_down(sleep_power_down), .prescaler_active(prescaler_active),
	.prescaled_clk(prescaled_clk), .src_osc_clk(src_osc_clk), .sys_clk_release(sys_clk_release),
	.rc_osc_run(rc_osc_run), .pll_run(pll_run), .pll_ref_select(pll_ref_select),
	.pll_mult_factor(pll_mult_factor), .system_clock_output_pin(system_clock_output_pin),
	.system_clock_output_pin_oe(system_clock_output_pin_oe));
`default_nettype wire
